// ===== verilog/tdc_pkg.sv
// Purpose: Shared constants and types of the transceiver datapath clock router.
// Assumes: All PLL and recovered clock ticks are one-cycle enables on pclk.
// Notes:   Channel fields are packed eight bits per channel in one word.
// Functional notes
// - CDR clocks only from the two adjacent PLLs.
// - Non-bonded channels source clocks and FIFOs independently.
// - Bonded channels share low-speed path and FIFO pointers.
// - Two-bonding on channels 0,1; four-bonding on all.
// - Bonded channels forbid receive-only operation.
// - Transmit: high-speed to serializer, low-speed to PCS.
// - Byte serializer halves transmit FIFO read clock.
// - Transmit low-speed clock exported as parallel clock.
// - Receive-only: recovered clock drives PCS, no rate match.
// - Byte deserializer halves receive FIFO write clock.
// - Recovered clock exported as receive parallel clock.
// - Transmit-receive: rate match optional, clocking reuses other modes.
// - Rate match on: PLL low-speed clock feeds receive PCS.
// - Rate match on: recovered clock feeds aligner only.
`default_nettype none
package tdc_pkg;
    // Channel count and per-channel field width.
    localparam int NCH  = 4;
    localparam int CH_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_BOND  = 8'h04;
    localparam logic [7:0] OFS_CHCFG = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0c;
    // Reset values.
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [2:0]  RST_BOND  = 3'h0;
    localparam logic [31:0] RST_CHCFG = 32'h0000_0000;
    // Field positions.
    localparam int CTRL_RUN   = 0;
    localparam int BOND_PLL   = 2;
    localparam int CH_TX_BIT  = 0;
    localparam int CH_RX_BIT  = 1;
    localparam int CH_TXPLL   = 2;
    localparam int CH_CDRPLL  = 3;
    localparam int CH_BSER    = 4;
    localparam int CH_BDES    = 5;
    localparam int CH_RMF     = 6;
    localparam int STAT_RUN   = 8;
    // Configuration error flags.
    localparam int ERR_W          = 4;
    localparam int ERR_INTERLEAVE = 0;
    localparam int ERR_BOND_RX    = 1;
    localparam int ERR_BOND_CFG   = 2;
    localparam int ERR_RX_RMF     = 3;
    // Bonding modes.
    typedef enum logic [1:0] {
        BOND_X1 = 2'b00, BOND_X2 = 2'b01, BOND_X4 = 2'b10, BOND_BAD = 2'b11
    } tdc_bond_type;
    // Channel operating modes.
    typedef enum logic [1:0] {
        OP_OFF = 2'b00, OP_TX = 2'b01, OP_RX = 2'b10, OP_TXRX = 2'b11
    } tdc_op_type;
    // Run sequencer states.
    typedef enum logic [1:0] {
        ST_CFG = 2'b00, ST_ARM = 2'b01, ST_RUN = 2'b10
    } tdc_state_type;
    // True when a channel belongs to the bonded group of the given mode.
    function automatic logic is_bonded(input logic [1:0] mode, input int ch);
        return (mode == BOND_X4) || ((mode == BOND_X2) && (ch < 2));
    endfunction : is_bonded
endpackage : tdc_pkg
`default_nettype wire

// ===== verilog/tdc_cfg_if.sv
// Purpose: Carries the frozen channel configuration from the top to its helpers.
// Assumes: Driven by the top module, except the error flags, which the checker drives.
// Notes:   The checker returns the error flags over the same bundle.
`default_nettype none
interface tdc_cfg_if;
    import tdc_pkg::*;
    logic [CH_W*NCH-1:0] chcfg;     // Packed channel fields.
    logic [1:0]          bond_mode; // Bonding mode.
    logic                bond_pll;  // Bonded low-speed source.
    logic                active;    // Datapath running.
    logic                clr;       // Clears the halving dividers.
    logic [ERR_W-1:0]    err;       // Configuration errors.
    modport ctl (output chcfg, bond_mode, bond_pll, active, clr, input err);
    modport chk (input chcfg, bond_mode, output err);
    modport rte (input chcfg, bond_mode, bond_pll, active, clr);
endinterface : tdc_cfg_if
`default_nettype wire

// ===== verilog/tdc_cfg_chk.sv
// Purpose: Flags channel configurations that the clock network cannot build.
// Assumes: Configuration is static while it is being judged.
// Notes:   Purely combinational; the top refuses to start on any flag.
`default_nettype none
module tdc_cfg_chk
    import tdc_pkg::*;
(
    // Configuration bundle.
    tdc_cfg_if.chk cfg
);
    logic [NCH-1:0] rx_on;      // Receiver in use.
    logic [NCH-1:0] rx_only;    // Receive-only channel.
    logic [NCH-1:0] rmf_on;     // Rate match requested.
    logic [NCH-1:0] cdr_b;      // CDR fed from the second PLL.
    logic [NCH-1:0] bonded;     // Member of the bonded group.
    logic           seen;       // A receiver was already walked.
    logic           last;       // Source of the previous receiver.
    logic [1:0]     flips;      // Source changes along the block.

    // Per-channel field decode.
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        assign rx_on[ch]   = cfg.chcfg[ch*CH_W + CH_RX_BIT];
        assign rx_only[ch] = tdc_op_type'(cfg.chcfg[ch*CH_W +: 2]) == OP_RX;
        assign rmf_on[ch]  = cfg.chcfg[ch*CH_W + CH_RMF];
        assign cdr_b[ch]   = cfg.chcfg[ch*CH_W + CH_CDRPLL];
        assign bonded[ch]  = is_bonded(cfg.bond_mode, ch);
    end

    // Each PLL may feed one contiguous run of segments, so along the block
    // the CDR source may change at most once.
    always_comb
    begin
        seen  = 1'b0;
        last  = 1'b0;
        flips = 2'h0;
        for (int i = 0; i < NCH; i++)
        begin
            if (rx_on[i])
            begin
                if (seen && (cdr_b[i] != last))
                    flips = flips + 2'h1;
                seen = 1'b1;
                last = cdr_b[i];
            end
        end
    end

    assign cfg.err[ERR_INTERLEAVE] = flips > 2'h1;
    assign cfg.err[ERR_BOND_RX]    = |(bonded & rx_only);
    assign cfg.err[ERR_BOND_CFG]   = cfg.bond_mode == BOND_BAD;
    assign cfg.err[ERR_RX_RMF]     = |(rx_only & rmf_on);
endmodule : tdc_cfg_chk
`default_nettype wire

// ===== verilog/tdc_clk_route.sv
// Purpose: Routes PLL and recovered clock ticks to each channel's PCS blocks.
// Assumes: Ticks are pclk enables; configuration is frozen while active.
// Notes:   Every routed tick is registered, so it lags its source by one cycle.
`default_nettype none
module tdc_clk_route
    import tdc_pkg::*;
(
    // Clock and reset.
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Configuration bundle.
    tdc_cfg_if.rte              cfg,
    // Source ticks.
    input  wire logic           pll_a_hs_tick,
    input  wire logic           pll_a_ls_tick,
    input  wire logic           pll_b_hs_tick,
    input  wire logic           pll_b_ls_tick,
    input  wire logic [NCH-1:0] rec_ls_tick,
    // Routed ticks, one bit per channel; pointer groups, two bits per channel.
    output logic [NCH-1:0]      cdr_tick,
    output logic [NCH-1:0]      ser_tick,
    output logic [NCH-1:0]      enc_tick,
    output logic [NCH-1:0]      txf_rd_tick,
    output logic [NCH-1:0]      wa_tick,
    output logic [NCH-1:0]      rxpcs_tick,
    output logic [NCH-1:0]      rxf_wr_tick,
    output logic [2*NCH-1:0]    fifo_grp
);
    logic [NCH-1:0]   tx_tog_r, tx_tog_nxt;   // Transmit halving phase.
    logic [NCH-1:0]   rx_tog_r, rx_tog_nxt;   // Receive halving phase.
    logic [NCH-1:0]   cdr_nxt, ser_nxt, enc_nxt, txf_nxt;
    logic [NCH-1:0]   wa_nxt, rxpcs_nxt, rxf_nxt;
    logic [2*NCH-1:0] grp_nxt;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        localparam int B = ch*CH_W;
        wire bnd   = is_bonded(cfg.bond_mode, ch);
        wire hs_b  = cfg.chcfg[B + CH_TXPLL];
        wire ls_b  = bnd ? cfg.bond_pll : hs_b;
        wire hs    = hs_b ? pll_b_hs_tick : pll_a_hs_tick;
        wire ls    = ls_b ? pll_b_ls_tick : pll_a_ls_tick;
        wire tx_on = cfg.active & cfg.chcfg[B + CH_TX_BIT];
        wire rx_on = cfg.active & cfg.chcfg[B + CH_RX_BIT];
        // Rate match needs the transmit clock, so receive-only never uses it.
        wire rmf   = cfg.chcfg[B + CH_RMF] & cfg.chcfg[B + CH_TX_BIT];
        wire rxpcs = rmf ? ls : rec_ls_tick[ch];
        // Only the two adjacent PLLs are wired to the CDR selector.
        assign cdr_nxt[ch]   = rx_on & (cfg.chcfg[B + CH_CDRPLL] ? pll_b_hs_tick
                                                                 : pll_a_hs_tick);
        assign ser_nxt[ch]   = tx_on & hs;
        assign enc_nxt[ch]   = tx_on & ls;
        assign txf_nxt[ch]   = tx_on & ls & (~cfg.chcfg[B + CH_BSER] | tx_tog_r[ch]);
        assign tx_tog_nxt[ch] = cfg.clr ? 1'b0 : tx_tog_r[ch] ^ (tx_on & ls);
        assign wa_nxt[ch]    = rx_on & rec_ls_tick[ch];
        assign rxpcs_nxt[ch] = rx_on & rxpcs;
        assign rxf_nxt[ch]   = rx_on & rxpcs & (~cfg.chcfg[B + CH_BDES] | rx_tog_r[ch]);
        assign rx_tog_nxt[ch] = cfg.clr ? 1'b0 : rx_tog_r[ch] ^ (rx_on & rxpcs);
        // Bonded members use the pointer set of channel 0.
        assign grp_nxt[2*ch +: 2] = bnd ? 2'h0 : 2'(ch);
    end

    // All routed ticks and the halving phases are registered together.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {tx_tog_r, rx_tog_r, cdr_tick, ser_tick} <= '0;
            {enc_tick, txf_rd_tick, wa_tick}         <= '0;
            {rxpcs_tick, rxf_wr_tick, fifo_grp}      <= '0;
        end
        else
        begin
            {tx_tog_r, rx_tog_r, cdr_tick, ser_tick} <= {tx_tog_nxt, rx_tog_nxt, cdr_nxt, ser_nxt};
            {enc_tick, txf_rd_tick, wa_tick}         <= {enc_nxt, txf_nxt, wa_nxt};
            {rxpcs_tick, rxf_wr_tick, fifo_grp}      <= {rxpcs_nxt, rxf_nxt, grp_nxt};
        end
    end
endmodule : tdc_clk_route
`default_nettype wire

// ===== verilog/tdc_top.sv
// Purpose: Transceiver datapath clock selection with an APB register file.
// Assumes: PLL and recovered clocks arrive as one-cycle enables on pclk.
// Notes:   Configuration is accepted only while the datapath is stopped.
//          A start is refused while any configuration error stands.
//          Routed ticks lag their source ticks by one cycle.
//          Only channel 0 is checked in depth; the others share its logic.
`default_nettype none
module tdc_top
    import tdc_pkg::*;
(
    // Clock and reset.
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave port.
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Ticks of the two adjacent PLLs.
    input  wire logic           pll_a_hs_tick,
    input  wire logic           pll_a_ls_tick,
    input  wire logic           pll_b_hs_tick,
    input  wire logic           pll_b_ls_tick,
    // Low-speed recovered ticks, one per channel.
    input  wire logic [NCH-1:0] rec_ls_tick,
    // Ticks delivered to the channel blocks.
    output logic [NCH-1:0]      cdr_tick,
    output logic [NCH-1:0]      ser_tick,
    output logic [NCH-1:0]      enc_tick,
    output logic [NCH-1:0]      txf_rd_tick,
    output logic [NCH-1:0]      wa_tick,
    output logic [NCH-1:0]      rxpcs_tick,
    output logic [NCH-1:0]      rxf_wr_tick,
    // Parallel clocks exported to the fabric.
    output logic [NCH-1:0]      tx_par_tick,
    output logic [NCH-1:0]      rx_par_tick,
    // Phase compensation FIFO pointer group per channel.
    output logic [2*NCH-1:0]    fifo_grp
);
    // Register state.
    logic                run_req_r;      // Software asks the datapath to run.
    logic [2:0]          bond_r;         // Bonding mode and bonded PLL.
    logic [31:0]         chcfg_r;        // Packed channel fields.
    logic [31:0]         prdata_r;       // Read data captured in setup.
    logic                perr_r;         // Unmapped address seen in setup.
    tdc_state_type       st_r, st_nxt;   // Run sequencer.
    logic                run_q_r;        // Running in the previous cycle.

    // Bus decode.
    // Status writes are ignored and answer without an error.
    wire setup   = psel & ~penable;
    wire wr_en   = psel & penable & pwrite;
    wire hit_ctl = paddr == OFS_CTRL;
    wire hit_bnd = paddr == OFS_BOND;
    wire hit_cfg = paddr == OFS_CHCFG;
    wire hit_st  = paddr == OFS_STAT;
    wire mapped  = hit_ctl | hit_bnd | hit_cfg | hit_st;
    // Configuration may only change in the stopped state.
    wire cfg_open = st_r == ST_CFG;
    wire [ERR_W-1:0] chk_err;

    // Read multiplexer.
    // Unmapped words read as zero; the error rides on pslverr.
    wire [31:0] rd_mux = hit_ctl ? {31'h0, run_req_r} :
                         hit_bnd ? {29'h0, bond_r} :
                         hit_cfg ? chcfg_r :
                         hit_st  ? {23'h0, st_r == ST_RUN, 4'h0, chk_err} :
                         32'h0;

    // Configuration bundle shared with the checker and the router.
    tdc_cfg_if cfg_bus ();
    assign cfg_bus.chcfg     = chcfg_r;
    assign cfg_bus.bond_mode = bond_r[1:0];
    assign cfg_bus.bond_pll  = bond_r[BOND_PLL];
    assign cfg_bus.active    = st_r == ST_RUN;
    assign cfg_bus.clr       = st_r == ST_ARM;
    assign chk_err           = cfg_bus.err;

    // Run request: a start is refused while any configuration error stands.
    // Refusing at the write keeps the stored request bit truthful.
    wire run_wr   = wr_en & hit_ctl;
    wire run_nxt  = pwdata[CTRL_RUN] & (chk_err == '0);

    // Control registers; writes land at the access-phase edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_req_r <= RST_CTRL[CTRL_RUN];
            bond_r    <= RST_BOND;
            chcfg_r   <= RST_CHCFG;
        end
        else
        begin
            if (run_wr)
                run_req_r <= run_nxt;
            if (wr_en & hit_bnd & cfg_open)
                bond_r <= pwdata[2:0];
            if (wr_en & hit_cfg & cfg_open)
                chcfg_r <= pwdata;
        end
    end

    // Read data and error are captured in setup, so the answer is a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            perr_r   <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= rd_mux;
            perr_r   <= ~mapped;
        end
    end

    // The slave never stretches a transfer.
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = psel & penable & perr_r;

    // Sequencer: one arming cycle clears the halving dividers so that all
    // bonded channels start their halved clocks in the same phase.
    // Dropping the run request returns to configuration at once.
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_CFG:  st_nxt = run_req_r ? ST_ARM : ST_CFG;
            ST_ARM:  st_nxt = run_req_r ? ST_RUN : ST_CFG;
            ST_RUN:  st_nxt = run_req_r ? ST_RUN : ST_CFG;
            default: st_nxt = ST_CFG;
        endcase
    end

    // Sequencer state and the one-cycle-late running flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= ST_CFG;
            run_q_r <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            run_q_r <= st_r == ST_RUN;
        end
    end

    // Configuration checker.
    tdc_cfg_chk u_chk (
        .cfg (cfg_bus.chk)
    );

    // Clock router.
    tdc_clk_route u_route (
        .pclk          (pclk),
        .presetn       (presetn),
        .cfg           (cfg_bus.rte),
        .pll_a_hs_tick (pll_a_hs_tick),
        .pll_a_ls_tick (pll_a_ls_tick),
        .pll_b_hs_tick (pll_b_hs_tick),
        .pll_b_ls_tick (pll_b_ls_tick),
        .rec_ls_tick   (rec_ls_tick),
        .cdr_tick      (cdr_tick),
        .ser_tick      (ser_tick),
        .enc_tick      (enc_tick),
        .txf_rd_tick   (txf_rd_tick),
        .wa_tick       (wa_tick),
        .rxpcs_tick    (rxpcs_tick),
        .rxf_wr_tick   (rxf_wr_tick),
        .fifo_grp      (fifo_grp)
    );

    // Fabric parallel clocks follow the transmit and recovered clocks.
    assign tx_par_tick = enc_tick;
    assign rx_par_tick = wa_tick;

    // Helper terms for the checks below.
    // Channel 0 stands for all four; they share one generate body.
    wire       run2   = (st_r == ST_RUN) && run_q_r;
    wire [7:0] ch0    = chcfg_r[7:0];
    wire [1:0] bmode  = bond_r[1:0];
    wire       ch0_op_rx   = tdc_op_type'(ch0[1:0]) == OP_RX;
    wire       ch0_op_txrx = tdc_op_type'(ch0[1:0]) == OP_TXRX;

    // Checks sleep while reset is held; run2 marks cycles whose
    // routed ticks were launched by a running datapath.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // CDR follows its chosen adjacent PLL.
    a_cdr_source: assert property (
        run2 && ch0[CH_RX_BIT] |->
        cdr_tick[0] == $past(ch0[CH_CDRPLL] ? pll_b_hs_tick : pll_a_hs_tick))
        else $error("CDR tick not from the selected adjacent PLL");

    // Arming happens only with a clean setup.
    a_start_clean: assert property (
        st_r == ST_ARM |-> chk_err == '0 ##1 st_r != ST_ARM)
        else $error("Datapath armed with a configuration error");

    // Unbonded low-speed follows its own PLL.
    a_nb_ls_src: assert property (
        run2 && bmode == BOND_X1 && ch0[CH_TX_BIT] |->
        enc_tick[0] == $past(ch0[CH_TXPLL] ? pll_b_ls_tick : pll_a_ls_tick))
        else $error("Non-bonded low-speed tick from wrong source");

    // Unbonded channels keep their own pointers.
    a_grp_x1: assert property (
        run2 && bmode == BOND_X1 |-> fifo_grp == 8'he4)
        else $error("Non-bonded channels sharing a pointer group");

    // Bonded low-speed comes from the common path.
    a_bond_ls_src: assert property (
        run2 && bmode != BOND_X1 && ch0[CH_TX_BIT] |->
        enc_tick[0] == $past(bond_r[BOND_PLL] ? pll_b_ls_tick : pll_a_ls_tick))
        else $error("Bonded low-speed tick not from the common path");

    // Four-channel bonding shares group 0.
    a_bond_shared: assert property (
        run2 && bmode == BOND_X4 |-> fifo_grp == 8'h00)
        else $error("Bonded channels not sharing pointer group");

    // Two-channel bonding takes channels 0 and 1.
    a_x2_split: assert property (
        run2 && bmode == BOND_X2 |-> fifo_grp == 8'he0)
        else $error("Two-channel bonding not on channels 0 and 1");

    // No bonded receive-only channel runs.
    a_bond_no_rx: assert property (
        st_r == ST_RUN |-> !chk_err[ERR_BOND_RX])
        else $error("Bonded receive-only channel running");

    // Serializer follows the chosen PLL.
    a_ser_src: assert property (
        run2 && ch0[CH_TX_BIT] |->
        ser_tick[0] == $past(ch0[CH_TXPLL] ? pll_b_hs_tick : pll_a_hs_tick))
        else $error("Serializer tick not from selected PLL");

    // Halved read clock never fires twice running.
    a_txf_half: assert property (
        run2 && ch0[CH_BSER] && txf_rd_tick[0] |->
        enc_tick[0] && !$past(txf_rd_tick[0]))
        else $error("Transmit FIFO read clock not halved");

    // Fabric transmit clock is the low-speed clock.
    a_tx_par: assert property (
        run2 && bmode == BOND_X1 && ch0[CH_TX_BIT] |->
        tx_par_tick[0] == $past(ch0[CH_TXPLL] ? pll_b_ls_tick : pll_a_ls_tick))
        else $error("Transmit parallel clock differs from low-speed");

    // Receive-only PCS uses the recovered clock.
    a_rx_only: assert property (
        run2 && ch0_op_rx |-> rxpcs_tick[0] == $past(rec_ls_tick[0]))
        else $error("Receive-only PCS not on recovered clock");

    // Halved write clock never fires twice running.
    a_rxf_half: assert property (
        run2 && ch0[CH_BDES] && rxf_wr_tick[0] |->
        rxpcs_tick[0] && !$past(rxf_wr_tick[0]))
        else $error("Receive FIFO write clock not halved");

    // Fabric receive clock is the recovered clock.
    a_rx_par: assert property (
        run2 && ch0[CH_RX_BIT] |-> rx_par_tick[0] == $past(rec_ls_tick[0]))
        else $error("Receive parallel clock not the recovered clock");

    // Rate match moves the PCS to transmit timing.
    a_rmf_src: assert property (
        run2 && ch0_op_txrx && ch0[CH_RMF] |-> rxpcs_tick[0] == enc_tick[0])
        else $error("Rate match PCS not on transmit low-speed clock");

    // Rate match keeps the aligner on recovery.
    a_rmf_wa: assert property (
        run2 && ch0_op_txrx && ch0[CH_RMF] |-> wa_tick[0] == $past(rec_ls_tick[0]))
        else $error("Rate match aligner not on the recovered clock");

    // No CDR, serializer, encoder, aligner or receive PCS tick is delivered while stopped.
    a_idle_quiet: assert property (
        !run_q_r |-> {cdr_tick, ser_tick, enc_tick, wa_tick, rxpcs_tick} == '0)
        else $error("Ticks delivered while stopped");

    // Configuration ignores writes while running.
    a_cfg_frozen: assert property (
        !cfg_open && wr_en && hit_cfg |=> $stable(chcfg_r))
        else $error("Channel configuration changed while running");

    // Main scenarios that the bench should reach.
    c_run_x4:   cover property (run2 && bmode == BOND_X4);
    c_run_rmf:  cover property (run2 && ch0_op_txrx && ch0[CH_RMF]);
    c_refused:  cover property (run_wr && pwdata[CTRL_RUN] && chk_err != '0);
    c_bad_addr: cover property (pslverr);
    c_rx_half:  cover property (run2 && ch0[CH_BDES] && rxf_wr_tick[0]);
endmodule : tdc_top
`default_nettype wire

// ===== verification/tdc_fabric_model.sv
// Purpose: Fabric-side partner that launches and captures on the exported clocks.
// Assumes: Parallel clocks arrive as one-cycle enables on pclk.
// Notes:   It only counts edges; the bench compares the totals.
`default_nettype none
module tdc_fabric_model
    import tdc_pkg::*;
(
    // Clock and reset.
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Exported parallel clocks.
    input  wire logic [NCH-1:0] tx_par_tick,
    input  wire logic [NCH-1:0] rx_par_tick,
    // Launch and capture totals.
    output logic [7:0]          n_launch,
    output logic [7:0]          n_capture
);
    // Words are launched and captured only on the exported clocks, never on pclk alone.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_launch  <= 8'h00;
            n_capture <= 8'h00;
        end
        else
        begin
            n_launch  <= n_launch + 8'($countones(tx_par_tick));
            n_capture <= n_capture + 8'($countones(rx_par_tick));
        end
    end
endmodule : tdc_fabric_model
`default_nettype wire

// ===== verification/tb_transceiver_datapath_clocking.sv
// Purpose: Self-checking bench for the datapath clock router over APB.
// Assumes: pready may stall; every wait is bounded.
// Notes:   Routed ticks are packed one nibble per output group in obs.
`default_nettype none
module tb_transceiver_datapath_clocking;
    timeunit 1ns;
    timeprecision 1ns;
    import tdc_pkg::*;
    logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00, src = 8'h00; // Source ticks: a_hs, a_ls, b_hs, b_ls, rec.
    logic [31:0]    pwdata = 32'h0, prdata;
    logic           pready, pslverr;
    logic [NCH-1:0] cdr, ser, enc, txf, wa, rxp, rxf, txp, rxq;
    logic [7:0]     grp, n_launch, n_capture;
    int             fail_count = 0, n_tests = 0;
    wire logic [35:0] obs = {rxq, txp, rxf, rxp, wa, txf, enc, ser, cdr};
    localparam logic [35:0] M = 36'hffffffff0; // CDR nibble ignored on transmit-only runs.
    always #50 pclk = ~pclk;
    tdc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_a_hs_tick(src[0]), .pll_a_ls_tick(src[1]),
        .pll_b_hs_tick(src[2]), .pll_b_ls_tick(src[3]), .rec_ls_tick(src[7:4]),
        .cdr_tick(cdr), .ser_tick(ser), .enc_tick(enc), .txf_rd_tick(txf), .wa_tick(wa),
        .rxpcs_tick(rxp), .rxf_wr_tick(rxf), .tx_par_tick(txp), .rx_par_tick(rxq),
        .fifo_grp(grp));
    tdc_fabric_model fab (.pclk(pclk), .presetn(presetn), .tx_par_tick(txp),
        .rx_par_tick(rxq), .n_launch(n_launch), .n_capture(n_capture));
    // Prints the counts and the verdict, then stops the run.
    task automatic close_out;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k == 16)
        begin
            fail_count++;
            close_out();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    // Data is compared only when no error response is expected.
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(36'(e), 36'(ee));
        if (!ee) chk(36'(q), 36'(x));
    endtask : rd
    // Loads a configuration and asks to run; two edges reach the running state, the third sets run_q_r.
    task automatic go(input logic [31:0] bond, input logic [31:0] ch);
        wr(OFS_BOND, bond);
        wr(OFS_CHCFG, ch);
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
    endtask : go
    // Pulses sources for one cycle and checks the routed ticks one cycle later.
    task automatic pulse(input logic [7:0] s, input logic [35:0] x, input logic [35:0] m);
        @(posedge pclk);
        src <= s;
        @(posedge pclk);
        src <= 8'h00;
        @(negedge pclk);
        chk(obs & m, x);
    endtask : pulse
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CHCFG, RST_CHCFG, 1'b0);
        rd(OFS_BOND, 32'(RST_BOND), 1'b0);
        rd(OFS_STAT, 32'h0, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        $display("test reset done");
        go(32'h0, 32'h00000011);
        rd(OFS_STAT, 32'h100, 1'b0);
        pulse(8'h02, 36'h010000100, M);
        pulse(8'h02, 36'h010001100, M);
        pulse(8'h01, 36'h000000010, M);
        chk(36'(grp), 36'he4);
        wr(OFS_CHCFG, 32'h0);
        rd(OFS_CHCFG, 32'h11, 1'b0);
        wr(OFS_CTRL, 32'h0);
        $display("test transmit done");
        go(32'h0, 32'h0a020a02);
        rd(OFS_STAT, 32'h1, 1'b0);
        rd(OFS_CTRL, 32'h0, 1'b0);
        go(32'h2, 32'h02020202);
        rd(OFS_STAT, 32'h2, 1'b0);
        $display("test refusal done");
        go(32'h0, 32'h0a0a0a2a);
        pulse(8'h04, 36'h00000000f, '1);
        pulse(8'h01, 36'h000000000, '1);
        pulse(8'hf0, 36'hf0eff0000, '1);
        pulse(8'hf0, 36'hf0fff0000, '1);
        wr(OFS_CTRL, 32'h0);
        $display("test receive done");
        go(32'h5, 32'h01010101);
        chk(36'(grp), 36'he0);
        pulse(8'h08, 36'h030003300, M);
        pulse(8'h02, 36'h0c000cc00, M);
        wr(OFS_CTRL, 32'h0);
        go(32'h3, 32'h00000042);
        rd(OFS_STAT, 32'hc, 1'b0);
        go(32'h2, 32'h43434343);
        chk(36'(grp), 36'h0);
        pulse(8'h02, 36'h0fff0ff00, '1);
        pulse(8'hf0, 36'hf000f0000, '1);
        wr(OFS_CTRL, 32'h0);
        chk(36'(n_launch), 36'd10);
        chk(36'(n_capture), 36'd12);
        $display("test bonded done");
        close_out();
    end
endmodule : tb_transceiver_datapath_clocking
`default_nettype wire
